/* dv/id_flash_model.sv */
// Identification flash as seen from the block's registered pins.
// Assumes pins sampled on the bridge clock.
`timescale 1ns/1ps
module id_flash_model (
    input  wire logic       clk,
    input  wire logic       cs_n,
    input  wire logic       we_n,
    input  wire logic       oe_n,
    input  wire logic       dq_oe_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] din,
    output logic      [7:0] dq
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    wire        rd   = !cs_n && we_n && !oe_n;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
    always @(posedge clk) begin
        if (!cs_n && !we_n && !dq_oe_n) mem[addr] <= din;
        if (rd) last <= mem[addr];
    end
    // Released bus never shows a stale copy
    assign dq = rd ? mem[addr] : ~last;
endmodule : id_flash_model

/* dv/local_bus_jtag_flash_gpio_monitor.sv */
// Checker on the top ports of the pin-control block.
// Assumes one request at a time and seven-clock flash cycles.
`timescale 1ns/1ps
module local_bus_jtag_flash_gpio_monitor #(
    parameter logic [15:0] BOARD_VARIANT = 16'h0000
) (
    input wire logic                     CLK,
    input wire logic                     SRST,
    input wire jtag_flash_pkg::bus_req_t REQ,
    input wire jtag_flash_pkg::bus_rsp_t RSP,
    input wire logic                     EXT_MASTER_REQ,
    input wire logic [7:0]               PIN_OUT,
    input wire logic [7:0]               PIN_OE_N,
    input wire logic                     FLASH_CS_N,
    input wire logic                     FLASH_WE_N,
    input wire logic                     FLASH_OE_N,
    input wire logic [7:0]               FLASH_ADDR,
    input wire logic [7:0]               FLASH_DQ_OUT,
    input wire logic                     FLASH_DQ_OE_N
);
    logic [3:0] busy;
    wire       take = REQ.valid && busy == 4'h0;
    wire       fl   = take && !REQ.cfg && REQ.space == jtag_flash_pkg::id_flash_space;
    wire       pin  = take && REQ.cfg && REQ.write && REQ.addr == 8'h54;
    wire [7:0] wd   = {REQ.wdata[23], REQ.wdata[20], REQ.wdata[17], REQ.wdata[14],
                       REQ.wdata[11], REQ.wdata[8], REQ.wdata[5], REQ.wdata[2]};
    always_ff @(posedge CLK) begin
        if (SRST) busy <= 4'h0;
        else if (busy != 4'h0) busy <= busy - 4'h1;
        else if (fl) busy <= 4'h7;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    variant_read_a: assert property (take && !REQ.cfg && !REQ.write && REQ.space == 2'h0
        |=> RSP.valid && RSP.rdata == {16'h0000, BOARD_VARIANT}) else $error("bad variant");
    // Wait count reaches zero one clock before the registered answer
    flash_answer_a: assert property (fl |=> !RSP.valid [*7] ##1 RSP.valid)
        else $error("flash answer late");
    flash_drive_a: assert property (fl && REQ.write && !FLASH_OE_N |=> !FLASH_DQ_OE_N &&
        FLASH_ADDR == $past(REQ.addr) && FLASH_DQ_OUT == $past(REQ.wdata[7:0])) else $error("dq");
    line_level_a: assert property (FLASH_CS_N == (PIN_OE_N[3] | PIN_OUT[3]) &&
        FLASH_WE_N == (PIN_OE_N[4] | PIN_OUT[4])) else $error("strobe level");
    oe_own_a: assert property (!EXT_MASTER_REQ [*5] |-> !FLASH_OE_N)
        else $error("output enable high");
    pins_free_a: assert property (EXT_MASTER_REQ [*5] |-> PIN_OE_N == 8'hff && FLASH_OE_N)
        else $error("pins driven");
    pin_data_a: assert property (pin && !REQ.wdata[9] |-> ##2 PIN_OUT == $past(wd, 2))
        else $error("pin data");
    reg_reserved_a: assert property (take && REQ.cfg && !REQ.write
        |=> (RSP.rdata & ~jtag_flash_pkg::pin_ctrl_writable) == 32'h0) else $error("reserved");
    cover property (fl && REQ.write);
    cover property (fl && !REQ.write);
    cover property (pin && !REQ.wdata[9]);
endmodule : local_bus_jtag_flash_gpio_monitor
bind local_bus_jtag_flash_gpio local_bus_jtag_flash_gpio_monitor #(.BOARD_VARIANT(BOARD_VARIANT))
    local_bus_jtag_flash_gpio_monitor_i (.CLK, .SRST, .REQ, .RSP, .EXT_MASTER_REQ, .PIN_OUT,
    .PIN_OE_N, .FLASH_CS_N, .FLASH_WE_N, .FLASH_OE_N, .FLASH_ADDR, .FLASH_DQ_OUT, .FLASH_DQ_OE_N);

/* dv/local_bus_jtag_flash_gpio_tb.sv */
// Testbench of the pin-control block with the flash model on its pins.
// Assumes the rack variant and a free-running scan clock from this bench.
`timescale 1ns/1ps
module local_bus_jtag_flash_gpio_tb;
    localparam logic [31:0] PV = 32'h00496e92;
    logic CLK = 1'b0, SRST = 1'b1, LINK_TCK = 1'b0, EXT_MASTER_REQ = 1'b1;
    jtag_flash_pkg::bus_req_t REQ = '0;
    jtag_flash_pkg::bus_rsp_t RSP;
    logic [7:0]  PIN_OUT, PIN_OE_N, FLASH_ADDR, FLASH_DQ_IN, FLASH_DQ_OUT;
    logic        FLASH_CS_N, FLASH_WE_N, FLASH_OE_N, FLASH_DQ_OE_N, hit;
    logic [31:0] r, pv;
    logic [63:0] seq;
    int          err_total = 0, cmp_count = 0;
    always #5 CLK = ~CLK;
    initial #3.3 forever #62.5 LINK_TCK = ~LINK_TCK;
    local_bus_jtag_flash_gpio #(.BOARD_VARIANT(16'h0001)) local_bus_jtag_flash_gpio_i (.CLK, .SRST,
        .LINK_TCK, .REQ, .RSP, .EXT_MASTER_REQ, .PIN_OUT, .PIN_OE_N, .FLASH_CS_N, .FLASH_WE_N,
        .FLASH_OE_N, .FLASH_ADDR, .FLASH_DQ_IN, .FLASH_DQ_OUT, .FLASH_DQ_OE_N);
    id_flash_model id_flash_model_i (.clk(CLK), .cs_n(FLASH_CS_N), .we_n(FLASH_WE_N),
        .oe_n(FLASH_OE_N), .dq_oe_n(FLASH_DQ_OE_N), .addr(FLASH_ADDR), .din(FLASH_DQ_OUT),
        .dq(FLASH_DQ_IN));
    task automatic conclude();
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc
    // Holds the request for its taking edge, then waits a bounded time for the answer
    task automatic acc(input logic c, input logic [1:0] s, input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        #1 REQ = '{1'b1, w, c, s, a, d};
        cyc(1);
        REQ.valid = 1'b0;
        while (RSP.valid !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if (n == 20) err_total++;
        r = RSP.rdata;
    endtask : acc
    task automatic fl(input logic w, input logic [7:0] a, input logic [7:0] d);
        acc(1'b0, 2'h3, w, a, {24'h0, d});
        cyc(3);
    endtask : fl
    initial begin
        cyc(3);
        SRST = 1'b0;
        acc(1'b1, 2'h0, 1'b0, 8'h54, 32'h0);
        chk(r & 32'hfbffffff, 32'h00249000);
        acc(1'b1, 2'h0, 1'b1, 8'h54, PV | 32'hf9000000);
        // A register write answers with the old contents; bit 26 is the live return
        chk(r & 32'hfbffffff, 32'h00249000);
        cyc(3);
        chk({24'h0, PIN_OE_N}, 32'hff);
        EXT_MASTER_REQ = 1'b0;
        cyc(6);
        chk({PIN_OE_N, FLASH_OE_N, FLASH_CS_N, FLASH_WE_N}, 32'h3);
        acc(1'b1, 2'h0, 1'b0, 8'h54, 32'h0);
        chk(r & 32'hfbffffff, PV);
        acc(1'b0, 2'h0, 1'b0, 8'h00, 32'h0);
        chk(r, 32'h1);
        for (int i = 1; i < 3; i++) begin
            acc(1'b0, 2'(i), 1'b0, 8'h00, 32'h0);
            chk(r, 32'h0);
        end
        acc(1'b1, 2'h0, 1'b1, 8'h54, PV & ~32'h4000);
        fl(1'b1, 8'h5a, 8'ha5);
        // Write answer carries the idle flash bus, which the model shows as the inverse of its last read, all ones before any read
        chk(r, 32'hff);
        acc(1'b1, 2'h0, 1'b1, 8'h54, PV);
        fl(1'b1, 8'h11, 8'h77);
        fl(1'b0, 8'h5a, 8'h00);
        chk(r, 32'ha5);
        fl(1'b0, 8'h11, 8'h00);
        chk(r, 32'h2d);
        pv = (PV & ~32'h200) | 32'h00120000;
        acc(1'b1, 2'h0, 1'b1, 8'h54, pv);
        cyc(60);
        pv |= 32'h20;
        acc(1'b1, 2'h0, 1'b1, 8'h54, pv);
        cyc(100);
        for (int i = 0; i < 64; i++) begin
            @(negedge LINK_TCK);
            acc(1'b1, 2'h0, 1'b1, 8'h54, i == 1 ? pv : pv & ~32'h00100000);
            acc(1'b1, 2'h0, 1'b0, 8'h54, 32'h0);
            seq[i] = r[26];
        end
        hit = 1'b0;
        for (int i = 0; i < 30; i++) hit |= seq[i +: 33] === {1'b1, 31'h0, 1'b1};
        chk({31'h0, hit}, 32'h1);
        EXT_MASTER_REQ = 1'b1;
        cyc(6);
        chk({PIN_OE_N, FLASH_OE_N}, 32'h1ff);
        conclude();
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule : local_bus_jtag_flash_gpio_tb

/* logic/jtag_flash_pkg.sv */
// Constants, field layout and carrier types for the local-bus pin-control block.
// Assumes a single 100 MHz bridge clock and a separate scan clock for the test logic.
package jtag_flash_pkg;

    // Bridge clock
    localparam int          clk_period_ns        = 10;

    // Bridge register at its printed offset
    localparam logic [7:0]  pin_ctrl_offset      = 8'h54;
    localparam logic [31:0] pin_ctrl_reset       = 32'h00249000;
    // Bit 24 and bits 31..27 are reserved and read as zero
    localparam logic [31:0] pin_ctrl_writable    = 32'h06ffffff;

    // Per-pin field layout of pins 0..7
    localparam int          pin_count            = 8;
    localparam int          field_stride         = 3;
    localparam int          field_fsel           = 0;
    localparam int          field_dir            = 1;
    localparam int          field_data           = 2;
    localparam int          scan_return_dir_bit  = 25;
    localparam int          scan_return_data_bit = 26;

    // Pin assignment
    localparam int          spare_low_pin        = 0;
    localparam int          scan_reset_pin       = 1;
    localparam int          spare_mid_pin        = 2;
    localparam int          id_select_pin        = 3;
    localparam int          id_write_pin         = 4;
    localparam int          scan_data_pin        = 5;
    localparam int          scan_mode_pin        = 6;
    localparam int          scan_clock_pin       = 7;

    // Local address spaces
    localparam logic [1:0]  variant_space        = 2'h0;
    localparam logic [1:0]  id_flash_space       = 2'h3;

    // Board-variant codes
    localparam logic [15:0] variant_external     = 16'h0000;
    localparam logic [15:0] variant_rack         = 16'h0001;

    // Identification flash access time, least time rounded up
    localparam int          flash_access_ns      = 70;
    localparam int          flash_wait_int       =
        (flash_access_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [3:0]  flash_wait_cycles    = 4'(flash_wait_int);

    // Test logic: instruction width, capture pattern and codes
    localparam logic [3:0]  ir_capture           = 4'h1;
    localparam logic [3:0]  instr_id             = 4'h1;
    localparam logic [31:0] scan_id_code         = 32'h00000001; // Arbitrary value

    typedef enum logic [1:0] {
        st_idle  = 2'b01,
        st_flash = 2'b10
    } bus_state_t;

    typedef enum logic [15:0] {
        tap_reset      = 16'h0001,
        tap_idle       = 16'h0002,
        tap_sel_dr     = 16'h0004,
        tap_cap_dr     = 16'h0008,
        tap_shift_dr   = 16'h0010,
        tap_exit1_dr   = 16'h0020,
        tap_pause_dr   = 16'h0040,
        tap_exit2_dr   = 16'h0080,
        tap_upd_dr     = 16'h0100,
        tap_sel_ir     = 16'h0200,
        tap_cap_ir     = 16'h0400,
        tap_shift_ir   = 16'h0800,
        tap_exit1_ir   = 16'h1000,
        tap_pause_ir   = 16'h2000,
        tap_exit2_ir   = 16'h4000,
        tap_upd_ir     = 16'h8000
    } tap_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        cfg;
        logic [1:0]  space;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } bus_rsp_t;

endpackage : jtag_flash_pkg

/* logic/level_sync.sv */
// Two-flop level synchroniser, synchronous active-high reset to all ones.
// Assumes the inputs are levels that stay stable for several destination clocks.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // Resetting to ones makes an unknown line look undriven, i.e. high
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : level_sync

/* logic/local_bus_jtag_flash_gpio.sv */
// Local-bus side of the bridge: pin control register, board variant, flash cycles
// and the scan test logic behind the bit-banged pins.
// Assumes requests come from the bridge core on CLK, one at a time.
`timescale 1ns/1ps
module local_bus_jtag_flash_gpio #(
    parameter logic [15:0] BOARD_VARIANT = jtag_flash_pkg::variant_external
) (
    input  wire logic                      CLK,
    input  wire logic                      SRST,
    input  wire logic                      LINK_TCK,
    input  wire jtag_flash_pkg::bus_req_t  REQ,
    output jtag_flash_pkg::bus_rsp_t       RSP,
    input  wire logic                      EXT_MASTER_REQ,
    output logic [7:0]                     PIN_OUT,
    output logic [7:0]                     PIN_OE_N,
    output logic                           FLASH_CS_N,
    output logic                           FLASH_WE_N,
    output logic                           FLASH_OE_N,
    output logic [7:0]                     FLASH_ADDR,
    input  wire logic [7:0]                FLASH_DQ_IN,
    output logic [7:0]                     FLASH_DQ_OUT,
    output logic                           FLASH_DQ_OE_N
);

    function automatic int pin_bit(input int pin, input int field);
        pin_bit = pin * jtag_flash_pkg::field_stride + field;
    endfunction : pin_bit

    logic [31:0]                  pin_ctrl;
    logic [31:0]                  next_pin_ctrl;
    jtag_flash_pkg::bus_state_t   state;
    jtag_flash_pkg::bus_state_t   next_state;
    logic [3:0]                   wait_count;
    logic [3:0]                   next_wait_count;
    logic [9:0]                   sync_out;
    logic                         ext_req_s;
    logic                         tdo_s;
    logic [7:0]                   dq_s;
    logic                         own;
    logic                         tap_tdo;
    logic [7:0]                   line_level;
    logic [7:0]                   next_line_level;
    logic [7:0]                   next_pin_out;
    logic [7:0]                   next_pin_oe_n;
    logic [7:0]                   pin_fsel;
    logic [7:0]                   pin_dir;
    logic [7:0]                   pin_data;
    logic [7:0]                   pin_src;
    logic                         flash_busy;
    logic                         take;
    logic                         take_cfg;
    logic                         take_var;
    logic                         take_flash;
    logic                         cfg_hit;
    logic                         ret_bit;
    logic [31:0]                  pin_read;
    logic [31:0]                  quick_rdata;
    logic                         flash_done;
    jtag_flash_pkg::bus_rsp_t     next_rsp;

    // Pin inputs pass two flops before use
    level_sync #(.WIDTH(10)) u_pin_sync (
        .clk  (CLK),
        .rst  (SRST),
        .din  ({EXT_MASTER_REQ, tap_tdo, FLASH_DQ_IN}),
        .dout (sync_out)
    );

    assign ext_req_s  = sync_out[9];
    assign tdo_s      = sync_out[8];
    assign dq_s       = sync_out[7:0];
    assign own        = ~ext_req_s;
    assign flash_busy = (state == jtag_flash_pkg::st_flash);

    // Request decode
    assign take       = REQ.valid & (state == jtag_flash_pkg::st_idle);
    assign take_cfg   = take & REQ.cfg;
    assign take_var   = take & ~REQ.cfg & (REQ.space == jtag_flash_pkg::variant_space);
    assign take_flash = take & ~REQ.cfg & (REQ.space == jtag_flash_pkg::id_flash_space);
    assign cfg_hit    = (REQ.addr == jtag_flash_pkg::pin_ctrl_offset);

    // Pin 8 reads the returned scan output while it is an input
    assign ret_bit  = pin_ctrl[jtag_flash_pkg::scan_return_dir_bit]
                    ? pin_ctrl[jtag_flash_pkg::scan_return_data_bit] : tdo_s;
    assign pin_read = (pin_ctrl & jtag_flash_pkg::pin_ctrl_writable
                       & ~(32'h1 << jtag_flash_pkg::scan_return_data_bit))
                    | ({31'h0, ret_bit} << jtag_flash_pkg::scan_return_data_bit);

    assign quick_rdata = take_cfg ? (cfg_hit ? pin_read : 32'h0)
                       : take_var ? {16'h0, BOARD_VARIANT}
                       : 32'h0;

    // Reserved bits are never stored, so they always read as zero
    assign next_pin_ctrl = (take_cfg & REQ.write & cfg_hit)
                         ? (REQ.wdata & jtag_flash_pkg::pin_ctrl_writable)
                         : pin_ctrl;

    generate
        for (genvar i = 0; i < jtag_flash_pkg::pin_count; i++) begin : g_pin
            assign pin_fsel[i]        = pin_ctrl[pin_bit(i, jtag_flash_pkg::field_fsel)];
            assign pin_dir[i]         = pin_ctrl[pin_bit(i, jtag_flash_pkg::field_dir)];
            assign pin_data[i]        = pin_ctrl[pin_bit(i, jtag_flash_pkg::field_data)];
            assign next_pin_oe_n[i]   = ~(own & pin_dir[i]);
            assign next_pin_out[i]    = pin_src[i];
            // A released line is pulled high at the far end
            assign next_line_level[i] = next_pin_oe_n[i] ? 1'b1 : pin_src[i];
        end
    endgenerate

    // Only pin 3 has a dedicated function: chip select from the space 3 decode
    always_comb begin
        pin_src = pin_data;
        if (pin_fsel[jtag_flash_pkg::id_select_pin]) begin
            pin_src[jtag_flash_pkg::id_select_pin] = ~flash_busy;
        end
    end

    // Flash cycle sequencing
    assign flash_done = flash_busy & (wait_count == 4'h0);

    always_comb begin
        next_state      = state;
        next_wait_count = wait_count;
        unique case (state)
            jtag_flash_pkg::st_idle: begin
                if (take_flash) begin
                    next_state      = jtag_flash_pkg::st_flash;
                    next_wait_count = jtag_flash_pkg::flash_wait_cycles - 4'h1;
                end
            end
            jtag_flash_pkg::st_flash: begin
                if (flash_done) begin
                    next_state = jtag_flash_pkg::st_idle;
                end else begin
                    next_wait_count = wait_count - 4'h1;
                end
            end
        endcase
    end

    assign next_rsp.valid = flash_done | (take & ~take_flash);
    assign next_rsp.rdata = flash_done ? {24'h0, dq_s} : quick_rdata;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_ctrl   <= jtag_flash_pkg::pin_ctrl_reset;
            state      <= jtag_flash_pkg::st_idle;
            wait_count <= 4'h0;
            RSP        <= '0;
        end else begin
            pin_ctrl   <= next_pin_ctrl;
            state      <= next_state;
            wait_count <= next_wait_count;
            RSP        <= next_rsp;
        end
    end

    // Pins and flash strobes, all registered
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PIN_OUT    <= 8'h00;
            PIN_OE_N   <= 8'hff;
            line_level <= 8'hff;
            FLASH_CS_N <= 1'b1;
            FLASH_WE_N <= 1'b1;
            FLASH_OE_N <= 1'b1;
        end else begin
            PIN_OUT    <= next_pin_out;
            PIN_OE_N   <= next_pin_oe_n;
            line_level <= next_line_level;
            FLASH_CS_N <= next_line_level[jtag_flash_pkg::id_select_pin];
            FLASH_WE_N <= next_line_level[jtag_flash_pkg::id_write_pin];
            FLASH_OE_N <= ~own;
        end
    end

    // Flash address and write data held for the whole cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FLASH_ADDR    <= 8'h00;
            FLASH_DQ_OUT  <= 8'h00;
            FLASH_DQ_OE_N <= 1'b1;
        end else if (take_flash) begin
            FLASH_ADDR    <= REQ.addr;
            FLASH_DQ_OUT  <= REQ.wdata[7:0];
            FLASH_DQ_OE_N <= ~(REQ.write & own);
        end else if (flash_done) begin
            FLASH_DQ_OE_N <= 1'b1;
        end
    end

    // Scan lines cross into the scan clock domain as registered levels
    scan_tap u_tap (
        .tck       (LINK_TCK),
        .trst_n    (line_level[jtag_flash_pkg::scan_reset_pin]),
        .tms_level (line_level[jtag_flash_pkg::scan_mode_pin]),
        .tdi_level (line_level[jtag_flash_pkg::scan_data_pin]),
        .tdo       (tap_tdo)
    );

endmodule : local_bus_jtag_flash_gpio

/* logic/scan_tap.sv */
// Test access port of the scan chain, clocked by the scan clock.
// Assumes mode and data levels come from flops of the bridge domain.
`timescale 1ns/1ps
module scan_tap (
    input  wire logic tck,
    input  wire logic trst_n,
    input  wire logic tms_level,
    input  wire logic tdi_level,
    output logic      tdo
);

    logic                    rst_meta;
    logic                    rst_hold;
    logic [1:0]              lines;
    logic                    tms;
    logic                    tdi;
    jtag_flash_pkg::tap_state_t state;
    jtag_flash_pkg::tap_state_t next_state;
    logic [3:0]              ir_shift;
    logic [3:0]              ir;
    logic [31:0]             dr_id;
    logic                    bypass;
    wire                     id_sel = (ir == jtag_flash_pkg::instr_id);

    // Release of the scan reset is synchronised; assertion acts at once
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            rst_meta <= 1'b0;
            rst_hold <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_hold <= rst_meta;
        end
    end

    level_sync #(.WIDTH(2)) u_line_sync (
        .clk  (tck),
        .rst  (~rst_hold),
        .din  ({tms_level, tdi_level}),
        .dout (lines)
    );

    assign tms = lines[1];
    assign tdi = lines[0];

    always_comb begin
        next_state = state;
        unique case (state)
            jtag_flash_pkg::tap_reset:    next_state = tms ? jtag_flash_pkg::tap_reset
                                                           : jtag_flash_pkg::tap_idle;
            jtag_flash_pkg::tap_idle:     next_state = tms ? jtag_flash_pkg::tap_sel_dr
                                                           : jtag_flash_pkg::tap_idle;
            jtag_flash_pkg::tap_sel_dr:   next_state = tms ? jtag_flash_pkg::tap_sel_ir
                                                           : jtag_flash_pkg::tap_cap_dr;
            jtag_flash_pkg::tap_cap_dr:   next_state = tms ? jtag_flash_pkg::tap_exit1_dr
                                                           : jtag_flash_pkg::tap_shift_dr;
            jtag_flash_pkg::tap_shift_dr: next_state = tms ? jtag_flash_pkg::tap_exit1_dr
                                                           : jtag_flash_pkg::tap_shift_dr;
            jtag_flash_pkg::tap_exit1_dr: next_state = tms ? jtag_flash_pkg::tap_upd_dr
                                                           : jtag_flash_pkg::tap_pause_dr;
            jtag_flash_pkg::tap_pause_dr: next_state = tms ? jtag_flash_pkg::tap_exit2_dr
                                                           : jtag_flash_pkg::tap_pause_dr;
            jtag_flash_pkg::tap_exit2_dr: next_state = tms ? jtag_flash_pkg::tap_upd_dr
                                                           : jtag_flash_pkg::tap_shift_dr;
            jtag_flash_pkg::tap_upd_dr:   next_state = tms ? jtag_flash_pkg::tap_sel_dr
                                                           : jtag_flash_pkg::tap_idle;
            jtag_flash_pkg::tap_sel_ir:   next_state = tms ? jtag_flash_pkg::tap_reset
                                                           : jtag_flash_pkg::tap_cap_ir;
            jtag_flash_pkg::tap_cap_ir:   next_state = tms ? jtag_flash_pkg::tap_exit1_ir
                                                           : jtag_flash_pkg::tap_shift_ir;
            jtag_flash_pkg::tap_shift_ir: next_state = tms ? jtag_flash_pkg::tap_exit1_ir
                                                           : jtag_flash_pkg::tap_shift_ir;
            jtag_flash_pkg::tap_exit1_ir: next_state = tms ? jtag_flash_pkg::tap_upd_ir
                                                           : jtag_flash_pkg::tap_pause_ir;
            jtag_flash_pkg::tap_pause_ir: next_state = tms ? jtag_flash_pkg::tap_exit2_ir
                                                           : jtag_flash_pkg::tap_pause_ir;
            jtag_flash_pkg::tap_exit2_ir: next_state = tms ? jtag_flash_pkg::tap_upd_ir
                                                           : jtag_flash_pkg::tap_shift_ir;
            jtag_flash_pkg::tap_upd_ir:   next_state = tms ? jtag_flash_pkg::tap_sel_dr
                                                           : jtag_flash_pkg::tap_idle;
        endcase
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            state <= jtag_flash_pkg::tap_reset;
        end else if (!rst_hold) begin
            state <= jtag_flash_pkg::tap_reset;
        end else begin
            state <= next_state;
        end
    end

    // Data enters on the rising scan clock edge
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_shift <= jtag_flash_pkg::ir_capture;
            ir       <= jtag_flash_pkg::instr_id;
            dr_id    <= jtag_flash_pkg::scan_id_code;
            bypass   <= 1'b0;
        end else begin
            if (state == jtag_flash_pkg::tap_reset) begin
                ir <= jtag_flash_pkg::instr_id;
            end
            if (state == jtag_flash_pkg::tap_cap_ir) begin
                ir_shift <= jtag_flash_pkg::ir_capture;
            end
            if (state == jtag_flash_pkg::tap_shift_ir) begin
                ir_shift <= {tdi, ir_shift[3:1]};
            end
            if (state == jtag_flash_pkg::tap_upd_ir) begin
                ir <= ir_shift;
            end
            if (state == jtag_flash_pkg::tap_cap_dr) begin
                dr_id  <= jtag_flash_pkg::scan_id_code;
                bypass <= 1'b0;
            end
            if (state == jtag_flash_pkg::tap_shift_dr) begin
                if (id_sel) begin
                    dr_id <= {tdi, dr_id[31:1]};
                end else begin
                    bypass <= tdi;
                end
            end
        end
    end

    // Output changes on the falling edge, half a cycle ahead of the next sample
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo <= 1'b1;
        end else if (state == jtag_flash_pkg::tap_shift_ir) begin
            tdo <= ir_shift[0];
        end else if (state == jtag_flash_pkg::tap_shift_dr) begin
            tdo <= id_sel ? dr_id[0] : bypass;
        end else begin
            tdo <= 1'b1;
        end
    end

endmodule : scan_tap
